// ==== hdl/crs_pkg.sv ====
package crs_pkg;

  // bus cycle kinds driven by the sequencer
  typedef enum logic [1:0] {
    CRS_BUS_IDLE,
    CRS_BUS_READ,
    CRS_BUS_WRITE
  } crs_bus_t;

  localparam logic [15:0] RESET_VEC_HI   = 16'hfffe;
  localparam logic [15:0] RESET_VEC_LO   = 16'hffff;
  localparam logic [15:0] SWI_VEC_HI     = 16'hfffc;
  localparam logic [15:0] VEC_TABLE_TOP  = 16'hfffa;
  localparam int          NUM_IRQ        = 29;
  localparam int          IRQ_IDX_W      = 5;
  localparam int          STACK_BYTES    = 5;
  localparam int          QUEUE_BYTES    = 3;
  localparam int          RESET_SEQ_CYC  = 6;
  localparam logic [7:0]  CCR_IMASK_BIT  = 8'h08;
  localparam logic [15:0] SP_RESET       = 16'h00ff;
  localparam logic [15:0] PC_RESET       = 16'h0000;
  localparam logic [7:0]  REG8_RESET     = 8'h00;
  localparam logic [7:0]  CCR_RESET      = 8'h08;
  localparam logic [2:0]  CNT_RESET      = 3'h0;

endpackage : crs_pkg

// ==== hdl/crs_irq_prio.sv ====
`timescale 1ns/10ps
// picks the highest-priority pending source; index 0 is highest
module crs_irq_prio (
  input  wire logic [crs_pkg::NUM_IRQ-1:0]   pend,  // pending requests
  output logic                               any,   // at least one pending
  output logic [crs_pkg::IRQ_IDX_W-1:0]      idx    // winning index
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    // scan from lowest priority upward so the highest priority wins
    for (int i = crs_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        any = 1'b1;
        idx = i[crs_pkg::IRQ_IDX_W-1:0];
      end
    end
  end

endmodule : crs_irq_prio

// ==== hdl/crs_sequencer.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - reset sources are power-on, watchdog timeout and active-low external pin.
// - any reset aborts current activity at once, no instruction boundary wait.
// - reset ends only after source check is done and pin is released.
// - after reset a 6-cycle sequence reads 0xFFFE/0xFFFF and fills queue.
// - interrupt waits for instruction end; return address is next instruction.
// - interrupt entry follows software trap; vector from highest pending source.
// - push pc low, pc high, index low, accumulator, condition codes in order.
// - after stacking, the interrupt mask bit is set.
// - then read vector high byte, then vector low byte.
// - after the vector reads, one idle bus cycle with no access.
// - then read three program bytes from the vector target into the queue.
// - after stacking, stack pointer is one below the condition code byte.
// - return pops context in reverse, then refills queue with three bytes.
// - high index byte is never saved or restored automatically.
// - several pending requests: the highest priority is taken first.
module crs_sequencer (
  input  wire logic                          mclk,          // 20 MHz cpu bus clock
  input  wire logic                          reset,         // sync reset, active high
  input  wire logic                          por_event,     // power-on reset pulse
  input  wire logic                          watchdog_timeout_source, // watchdog reset
  input  wire logic                          ext_reset_n,   // external reset pin, low active
  input  wire logic                          src_check_done,// reset source check complete
  input  wire logic [crs_pkg::NUM_IRQ-1:0]   irq_pend,      // masked-in hw requests
  input  wire logic                          swi_req,       // software trap decoded
  input  wire logic                          rti_req,       // return from interrupt decoded
  input  wire logic                          insn_boundary, // current instruction finished
  input  wire logic [15:0]                   next_pc,       // start of next instruction
  input  wire logic [7:0]                    index_lo,      // index low register
  input  wire logic [7:0]                    acc,           // accumulator
  input  wire logic [7:0]                    ccr_in,        // live condition codes
  input  wire logic [15:0]                   sp_in,         // live stack pointer
  input  wire logic [7:0]                    rdata,         // memory read data
  output logic [15:0]                        addr,          // bus address
  output logic [7:0]                         wdata,         // bus write data
  output crs_pkg::crs_bus_t                  bus_op,        // bus cycle kind
  output logic                               core_hold,     // core stalled by sequencer
  output logic                               queue_load,    // this read cycle fetches a queue byte
  output logic                               ctx_load,      // load new context at the end of each sequence
  output logic [15:0]                        pc_out,        // new program counter
  output logic [15:0]                        sp_out,        // new stack pointer
  output logic [7:0]                         ccr_out,       // new condition codes
  output logic [7:0]                         acc_out,       // restored accumulator
  output logic [7:0]                         index_lo_out,  // restored index low
  output logic                               in_reset       // reset event in progress
);

  typedef enum logic [3:0] {
    CRS_RUN, CRS_RST, CRS_VEC_HI, CRS_VEC_LO, CRS_PAD, CRS_FILL,
    CRS_PUSH, CRS_IDLE, CRS_POP
  } crs_state_t;

  crs_state_t                      st_q, st_d;
  logic [2:0]                      cnt_q, cnt_d;
  logic [15:0]                     pc_q, pc_d;
  logic [15:0]                     pco_q, pco_d;      // target past the queued bytes
  logic                            inrst_q, inrst_d;
  logic [15:0]                     fill_base;
  logic [15:0]                     sp_q, sp_d;
  logic [15:0]                     vec_q, vec_d;
  logic [7:0]                      ccr_q, ccr_d;
  logic [7:0]                      acc_q, acc_d;
  logic [7:0]                      x_q, x_d;
  logic [15:0]                     addr_q, addr_d;
  logic [7:0]                      wdata_q, wdata_d;
  crs_pkg::crs_bus_t               op_q, op_d;
  logic                            hold_q, hold_d;
  logic                            qld_q, qld_d;
  logic                            ctx_q, ctx_d;
  logic                            irq_any;
  logic [crs_pkg::IRQ_IDX_W-1:0]   irq_idx;
  logic                            rst_evt;

  ////////////////////////////////////////////////////////////////////////
  crs_irq_prio u_prio (
    .pend (irq_pend),
    .any  (irq_any),
    .idx  (irq_idx)
  );

  assign rst_evt = reset | por_event | watchdog_timeout_source | ~ext_reset_n;

  // vector pair for source n sits just below the trap vector, two bytes each
  function automatic logic [15:0] irq_vec(input logic [crs_pkg::IRQ_IDX_W-1:0] n);
    irq_vec = crs_pkg::VEC_TABLE_TOP - {10'h000, n, 1'b0};
  endfunction : irq_vec

  // stack byte k of the frame, pushed in order k = 0..4
  function automatic logic [7:0] frame_byte(input logic [2:0] k, input logic [15:0] pc,
                                            input logic [7:0] x, input logic [7:0] a,
                                            input logic [7:0] c);
    case (k)
      3'h0:    frame_byte = pc[7:0];
      3'h1:    frame_byte = pc[15:8];
      3'h2:    frame_byte = x;
      3'h3:    frame_byte = a;
      default: frame_byte = c;
    endcase
  endfunction : frame_byte

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    pco_d   = pco_q;
    pc_d    = pc_q;
    fill_base = pc_q;
    sp_d    = sp_q;
    vec_d   = vec_q;
    ccr_d   = ccr_q;
    acc_d   = acc_q;
    x_d     = x_q;
    addr_d  = addr_q;
    wdata_d = 8'h00;
    op_d    = crs_pkg::CRS_BUS_IDLE;
    hold_d  = 1'b1;
    qld_d   = 1'b0;
    ctx_d   = 1'b0;
    case (st_q)
      CRS_RUN: begin
        hold_d = 1'b0;
        // track live registers so the context outputs stand valid after an entry
        acc_d  = acc;
        x_d    = index_lo;
        // requests sampled only at an instruction end
        if (insn_boundary && (irq_any || swi_req)) begin
          st_d   = CRS_PUSH;
          cnt_d  = crs_pkg::CNT_RESET;
          pc_d   = next_pc;
          sp_d   = sp_in;
          ccr_d  = ccr_in;
          // vector frozen when the sequence starts; hw ahead of trap
          vec_d  = irq_any ? irq_vec(irq_idx) : crs_pkg::SWI_VEC_HI;
          hold_d = 1'b1;
          op_d   = crs_pkg::CRS_BUS_WRITE;
          addr_d = sp_in;
          wdata_d = frame_byte(3'h0, next_pc, index_lo, acc, ccr_in);
          sp_d   = sp_in - 16'h0001;
          cnt_d  = 3'h1;
        end else if (insn_boundary && rti_req) begin
          st_d   = CRS_POP;
          cnt_d  = crs_pkg::CNT_RESET;
          sp_d   = sp_in + 16'h0001;
          op_d   = crs_pkg::CRS_BUS_READ;
          addr_d = sp_in + 16'h0001;
          hold_d = 1'b1;
        end
      end
      CRS_RST: begin
        if (src_check_done && ext_reset_n) begin
          st_d   = CRS_VEC_HI;
          vec_d  = crs_pkg::RESET_VEC_HI;
          ccr_d  = crs_pkg::CCR_RESET;
          cnt_d  = crs_pkg::CNT_RESET;
        end
      end
      CRS_PUSH: begin
        op_d    = crs_pkg::CRS_BUS_WRITE;
        addr_d  = sp_q;
        wdata_d = frame_byte(cnt_q, pc_q, index_lo, acc, ccr_q);
        sp_d    = sp_q - 16'h0001;
        cnt_d   = cnt_q + 3'h1;
        if (cnt_q == 3'(crs_pkg::STACK_BYTES - 1)) begin
          st_d  = CRS_VEC_HI;
          ccr_d = ccr_q | crs_pkg::CCR_IMASK_BIT;
        end
      end
      CRS_VEC_HI: begin
        op_d   = crs_pkg::CRS_BUS_READ;
        addr_d = vec_q;
        st_d   = CRS_VEC_LO;
      end
      CRS_VEC_LO: begin
        op_d   = crs_pkg::CRS_BUS_READ;
        addr_d = vec_q + 16'h0001;
        st_d   = CRS_PAD;
      end
      CRS_PAD: begin
        // vector high byte answers now; the low byte lands during the first fill
        pc_d[15:8] = rdata;
        st_d   = CRS_FILL;
        cnt_d  = crs_pkg::CNT_RESET;
      end
      CRS_POP: begin
        // reverse order: ccr, acc, index low, pc high, pc low
        // each byte answers a cycle after its read; pc low is taken by the first fill
        cnt_d = cnt_q + 3'h1;
        case (cnt_q)
          3'h1:    ccr_d = rdata;
          3'h2:    acc_d = rdata;
          3'h3:    x_d   = rdata;
          3'h4:    pc_d[15:8] = rdata;
          default: ;
        endcase
        if (cnt_q == 3'(crs_pkg::STACK_BYTES - 1)) begin
          st_d  = CRS_FILL;
          cnt_d = crs_pkg::CNT_RESET;
        end else begin
          op_d   = crs_pkg::CRS_BUS_READ;
          sp_d   = sp_q + 16'h0001;
          addr_d = sp_q + 16'h0001;
        end
      end
      CRS_FILL: begin
        // pc low byte arrives one cycle late, so it feeds the first fetch directly
        if (cnt_q == crs_pkg::CNT_RESET) begin
          fill_base = {pc_q[15:8], rdata};
          pc_d[7:0] = rdata;
        end
        op_d   = crs_pkg::CRS_BUS_READ;
        addr_d = fill_base + {13'h0000, cnt_q};
        qld_d  = 1'b1;
        cnt_d  = cnt_q + 3'h1;
        if (cnt_q == 3'(crs_pkg::QUEUE_BYTES - 1)) begin
          st_d  = CRS_IDLE;
          ctx_d = 1'b1;
          pco_d = pc_q + 16'(crs_pkg::QUEUE_BYTES);
        end
      end
      CRS_IDLE: begin
        // last queue byte read is on the bus; core resumes next cycle
        hold_d = 1'b0;
        st_d   = CRS_RUN;
      end
      default: st_d = CRS_RST;
    endcase
    // reset wins over everything, mid-instruction or mid-sequence
    if (rst_evt) begin
      st_d   = CRS_RST;
      op_d   = crs_pkg::CRS_BUS_IDLE;
      hold_d = 1'b1;
      qld_d  = 1'b0;
      ctx_d  = 1'b0;
      cnt_d  = crs_pkg::CNT_RESET;
    end
    inrst_d = (st_d == CRS_RST);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q    <= CRS_RST;
      cnt_q   <= crs_pkg::CNT_RESET;
      pco_q   <= crs_pkg::PC_RESET;
      inrst_q <= 1'b1;
      pc_q    <= crs_pkg::PC_RESET;
      sp_q    <= crs_pkg::SP_RESET;
      vec_q   <= crs_pkg::RESET_VEC_HI;
      ccr_q   <= crs_pkg::CCR_RESET;
      acc_q   <= crs_pkg::REG8_RESET;
      x_q     <= crs_pkg::REG8_RESET;
      addr_q  <= crs_pkg::RESET_VEC_HI;
      wdata_q <= crs_pkg::REG8_RESET;
      op_q    <= crs_pkg::CRS_BUS_IDLE;
      hold_q  <= 1'b1;
      qld_q   <= 1'b0;
      ctx_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      pco_q   <= pco_d;
      inrst_q <= inrst_d;
      pc_q    <= pc_d;
      sp_q    <= sp_d;
      vec_q   <= vec_d;
      ccr_q   <= ccr_d;
      acc_q   <= acc_d;
      x_q     <= x_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      op_q    <= op_d;
      hold_q  <= hold_d;
      qld_q   <= qld_d;
      ctx_q   <= ctx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // every output is a flop; acc/index follow the core while running
  assign addr         = addr_q;
  assign wdata        = wdata_q;
  assign bus_op       = op_q;
  assign core_hold    = hold_q;
  assign queue_load   = qld_q;
  assign ctx_load     = ctx_q;
  assign pc_out       = pco_q;
  assign sp_out       = sp_q;
  assign ccr_out      = ccr_q;
  assign acc_out      = acc_q;
  assign index_lo_out = x_q;
  assign in_reset     = inrst_q;

endmodule : crs_sequencer

// ==== dv/crs_mem_model.sv ====
`timescale 1ns/10ps
// memory side of the bus: answers a read on the next cycle
module crs_mem_model (
  input  wire logic              mclk,   // bus clock
  input  wire logic [15:0]       addr,   // bus address
  input  wire crs_pkg::crs_bus_t bus_op, // cycle kind
  output logic [7:0]             rdata   // read data
);
  // data toggles when not answering so a late sample never looks valid
  always_ff @(posedge mclk) begin
    if (bus_op == crs_pkg::CRS_BUS_READ) rdata <= addr[15:8] ^ addr[7:0];
    else rdata <= ~rdata;
  end
endmodule : crs_mem_model

// ==== dv/crs_seq_chk.sv ====
`timescale 1ns/10ps
module crs_seq_chk (
  input wire logic              mclk,                    // clock
  input wire logic              reset,                   // reset
  input wire logic              por_event,               // power-on
  input wire logic              watchdog_timeout_source, // watchdog
  input wire logic              ext_reset_n,             // pin
  input wire logic              src_check_done,          // check done
  input wire logic [28:0]       irq_pend,                // requests
  input wire logic              insn_boundary,           // boundary
  input wire logic              core_hold,               // stall
  input wire logic [15:0]       next_pc,                 // next pc
  input wire logic [15:0]       sp_in,                   // sp
  input wire logic [15:0]       addr,                    // address
  input wire logic [7:0]        wdata,                   // write data
  input wire crs_pkg::crs_bus_t bus_op,                  // cycle kind
  input wire logic              queue_load,              // fill
  input wire logic              ctx_load,                // ctx valid
  input wire logic [15:0]       sp_out,                  // new sp
  input wire logic [7:0]        ccr_out,                 // new codes
  input wire logic              in_reset                 // in reset
);
  logic        rst_src, rd, wr;
  logic [7:0]  pc_lo;
  logic [15:0] last_wr_d, last_wr_q;
  always_comb begin
    rst_src   = por_event | watchdog_timeout_source | ~ext_reset_n;
    rd        = bus_op == crs_pkg::CRS_BUS_READ;
    wr        = bus_op == crs_pkg::CRS_BUS_WRITE;
    pc_lo     = next_pc[7:0];
    last_wr_d = wr ? addr : last_wr_q;
  end
  always_ff @(posedge mclk) last_wr_q <= last_wr_d;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_abort;
    rst_src |=> in_reset && bus_op == crs_pkg::CRS_BUS_IDLE && core_hold;
  endproperty
  a_rst_abort: assert property (p_rst_abort) else $error("reset not taken");
  property p_rst_wait;
    in_reset && !src_check_done |=> in_reset;
  endproperty
  a_rst_wait: assert property (p_rst_wait) else $error("reset left early");
  property p_rst_vec;
    $fell(in_reset) |-> ##[0:1] (rd && addr == 16'hfffe) ##1 (rd && addr == 16'hffff);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("bad reset fetch");
  property p_entry;
    !in_reset && !rst_src && insn_boundary && !core_hold && irq_pend != '0
      |=> wr && addr == $past(sp_in) && wdata == $past(pc_lo);
  endproperty
  a_entry: assert property (p_entry) else $error("entry not started");
  property p_stk_desc;
    wr && $past(wr) |-> addr == $past(addr) - 16'h1;
  endproperty
  a_stk_desc: assert property (p_stk_desc) else $error("stack not descending");
  property p_vec_rd;
    disable iff (reset || rst_src)
    rd && addr[15:8] == 8'hff && !addr[0] |=> rd && addr == $past(addr) + 16'h1;
  endproperty
  a_vec_rd: assert property (p_vec_rd) else $error("vector pair broken");
  property p_vec_idle;
    disable iff (reset || rst_src)
    rd && addr[15:8] == 8'hff && addr[0]
      |=> bus_op == crs_pkg::CRS_BUS_IDLE ##1 (rd && queue_load) [*3];
  endproperty
  a_vec_idle: assert property (p_vec_idle) else $error("no idle then fill");
  property p_mask;
    disable iff (reset || rst_src)
    wr ##1 (!wr && !in_reset) |-> ##[5:7] ctx_load && (ccr_out & crs_pkg::CCR_IMASK_BIT) != 8'h00
      && sp_out == last_wr_q - 16'h1;
  endproperty
  a_mask: assert property (p_mask) else $error("mask or sp wrong");
endmodule : crs_seq_chk

bind crs_sequencer crs_seq_chk chk_u (.mclk, .reset, .por_event, .watchdog_timeout_source,
  .ext_reset_n, .src_check_done, .irq_pend, .insn_boundary, .core_hold, .next_pc, .sp_in,
  .addr, .wdata, .bus_op, .queue_load, .ctx_load, .sp_out, .ccr_out, .in_reset);

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  localparam logic [1:0] RD = 2'h1;
  localparam logic [1:0] WR = 2'h2;
  logic              mclk, reset, por_event, wdt, ext_reset_n, src_check_done, swi_req;
  logic              rti_req, insn_boundary, core_hold, queue_load, ctx_load, in_reset;
  logic [28:0]       irq_pend;
  logic [15:0]       next_pc, sp_in, addr, pc_out, sp_out;
  logic [7:0]        index_lo, acc, ccr_in, rdata, wdata, ccr_out, acc_out, index_lo_out;
  crs_pkg::crs_bus_t bus_op;
  logic [25:0]       log_q[$];
  logic [55:0]       ctx_q;
  logic [7:0]        stk [5] = '{8'h34, 8'h12, 8'h5c, 8'ha7, 8'h61};
  int                error_cnt = 0;
  int                n_tests = 0;
  crs_sequencer dut_u (.mclk, .reset, .por_event, .watchdog_timeout_source(wdt), .ext_reset_n,
    .src_check_done, .irq_pend, .swi_req, .rti_req, .insn_boundary, .next_pc, .index_lo, .acc,
    .ccr_in, .sp_in, .rdata, .addr, .wdata, .bus_op, .core_hold, .queue_load, .ctx_load,
    .pc_out, .sp_out, .ccr_out, .acc_out, .index_lo_out, .in_reset);
  crs_mem_model mem_u (.mclk, .addr, .bus_op, .rdata);
  always @(posedge mclk) begin
    if (bus_op !== crs_pkg::CRS_BUS_IDLE) log_q.push_back({bus_op, addr, wr_byte()});
    if (ctx_load === 1'b1) ctx_q = {pc_out, sp_out, ccr_out, acc_out, index_lo_out};
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] wr_byte();
    return (bus_op === crs_pkg::CRS_BUS_WRITE) ? wdata : 8'h00;
  endfunction : wr_byte
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[15:8] ^ a[7:0];
  endfunction : mb
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic wait_free();
    // let the edge that took the request settle before looking at hold
    @(negedge mclk);
    for (int i = 0; core_hold !== 1'b0; i++) begin
      if (i == 60) begin
        error_cnt++;
        stop_test();
      end
      @(negedge mclk);
    end
  endtask : wait_free
  task automatic chk_fill(input int i, input logic [15:0] t);
    for (int k = 0; k < 3; k++) chk(log_q[i + k], {RD, t + 16'(k), 8'h00});
  endtask : chk_fill
  task automatic chk_boot();
    chk(26'(log_q.size()), 5);
    chk(log_q[0], {RD, 16'hfffe, 8'h00});
    chk(log_q[1], {RD, 16'hffff, 8'h00});
    chk_fill(2, 16'h0100);
  endtask : chk_boot
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_entry(input logic [28:0] pend, input logic sw, input logic [15:0] v);
    logic [15:0] t;
    t = {mb(v), mb(v + 16'h1)};
    @(posedge mclk);
    irq_pend <= pend;
    swi_req <= sw;
    repeat (3) @(negedge mclk);
    chk(bus_op, 0);
    log_q.delete();
    @(posedge mclk);
    insn_boundary <= 1'b1;
    @(posedge mclk);
    insn_boundary <= 1'b0;
    irq_pend <= '0;
    swi_req <= 1'b0;
    wait_free();
    chk(26'(log_q.size()), 10);
    for (int k = 0; k < 5; k++) chk(log_q[k], {WR, 16'h00f0 - 16'(k), stk[k]});
    chk(log_q[5], {RD, v, 8'h00});
    chk(log_q[6], {RD, v + 16'h1, 8'h00});
    chk_fill(7, t);
    chk(ctx_q[55:24], {t + 16'h3, 16'h00eb});
    chk(ctx_q[19], 1'b1);
    $display("entry test done");
  endtask : t_entry
  task automatic t_return();
    @(posedge mclk);
    log_q.delete();
    rti_req <= 1'b1;
    insn_boundary <= 1'b1;
    @(posedge mclk);
    rti_req <= 1'b0;
    insn_boundary <= 1'b0;
    wait_free();
    chk(26'(log_q.size()), 8);
    for (int k = 0; k < 5; k++) chk(log_q[k], {RD, 16'h00f1 + 16'(k), 8'h00});
    chk_fill(5, 16'hf4f5);
    chk(ctx_q, {16'hf4f8, 16'h00f5, 8'hf1, 8'hf2, 8'hf3});
    $display("return test done");
  endtask : t_return
  // abort lands during stacking, so the entry is never completed
  task automatic t_reset(input int s);
    @(posedge mclk);
    irq_pend <= 29'h1;
    insn_boundary <= 1'b1;
    @(posedge mclk);
    insn_boundary <= 1'b0;
    irq_pend <= '0;
    repeat (2) @(posedge mclk);
    src_check_done <= 1'b0;
    por_event <= (s == 0);
    wdt <= (s == 1);
    ext_reset_n <= (s != 2);
    @(posedge mclk);
    por_event <= 1'b0;
    wdt <= 1'b0;
    @(negedge mclk);
    chk({in_reset, bus_op}, {1'b1, 2'h0});
    @(posedge mclk);
    src_check_done <= (s == 2);
    repeat (3) @(negedge mclk);
    chk(in_reset, 1'b1);
    log_q.delete();
    @(posedge mclk);
    src_check_done <= 1'b1;
    ext_reset_n <= 1'b1;
    wait_free();
    chk_boot();
    $display("reset test done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {reset, ext_reset_n, src_check_done} = 3'h7;
    {por_event, wdt, swi_req, rti_req, insn_boundary} = 5'h0;
    irq_pend = '0;
    {next_pc, sp_in, index_lo, acc, ccr_in} = {16'h1234, 16'h00f0, 8'h5c, 8'ha7, 8'h61};
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    // drop what was logged before the bus came out of reset
    log_q.delete();
    wait_free();
    chk_boot();
    t_entry(29'h88, 1'b0, 16'hfff4);
    t_entry(29'h0, 1'b1, 16'hfffc);
    t_entry(29'h1000_0000, 1'b1, 16'hffc2);
    t_return();
    for (int s = 0; s < 3; s++) t_reset(s);
    stop_test();
  end
endmodule : testbench
